// [design/core_agent_end.sv]
/*
  Far end of the error link: the processor core's reset and acknowledge
  behaviour plus a PCI agent that drives phases, parity, SERR and PERR.
  Assumes pclk is shared with the error reporting unit.
*/
`timescale 1ns/10ps
`default_nettype none
module core_agent_end (
  input wire logic pclk,
  input wire logic presetn,
  err_link_if.agent link,
  input wire logic sys_reset_req,
  input wire logic nmi_req,
  input wire logic core_machine_check_enable,
  input wire err_pkg::phase_t drv_phase,
  input wire logic [31:0] drv_ad,
  input wire logic [3:0] drv_cbe,
  input wire logic drv_special,
  input wire logic report_serr,
  input wire logic parity_check_en,
  output logic mck_taken,
  output logic checkstop
);
  logic hard_reset_n_reg;
  logic nmi_reg;
  err_pkg::ack_state_t ack_state_reg;
  err_pkg::phase_t drv_phase_reg;
  logic [31:0] drv_ad_reg;
  logic [3:0] drv_cbe_reg;
  logic drv_special_reg;
  logic par_reg;
  logic serr_oe_reg;
  logic perr_oe_reg;
  err_pkg::phase_t rx_phase_q;
  logic [31:0] rx_ad_q;
  logic [3:0] rx_cbe_q;
  logic rx_special_q;
  logic rx_bad;

  // ----------------------------------------
  // Reset and sideband
  // ----------------------------------------
  // One flop feeds both resets so they can never part
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hard_reset_n_reg <= 1'b0;
      nmi_reg <= 1'b0;
    end else begin
      hard_reset_n_reg <= !sys_reset_req;
      nmi_reg <= nmi_req;
    end
  end
  assign link.core_hard_reset_n = hard_reset_n_reg;
  assign link.controller_hard_reset_n = hard_reset_n_reg;
  assign link.nmi = nmi_reg;

  // ----------------------------------------
  // Machine-check acknowledge
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_state_reg <= err_pkg::AK_IDLE;
      checkstop <= 1'b0;
    end else begin
      unique case (ack_state_reg)
        err_pkg::AK_IDLE: begin
          if (!link.mcp_n && core_machine_check_enable) begin
            ack_state_reg <= err_pkg::AK_READ;
          end else if (!link.mcp_n) begin
            checkstop <= 1'b1;
          end
        end
        err_pkg::AK_READ: begin
          ack_state_reg <= err_pkg::AK_WAIT;
        end
        err_pkg::AK_WAIT: begin
          if (link.mcp_n) begin
            ack_state_reg <= err_pkg::AK_IDLE;
          end
        end
        default: begin
          ack_state_reg <= err_pkg::AK_IDLE;
        end
      endcase
    end
  end
  // Vector fetch is the acknowledge the unit waits for
  assign link.proc_rd_valid = (ack_state_reg == err_pkg::AK_READ);
  assign link.proc_rd_addr = err_pkg::MCK_VEC_HIGH_BASE;
  assign mck_taken = (ack_state_reg == err_pkg::AK_READ);

  // ----------------------------------------
  // PCI drive, parity, SERR, PERR
  // ----------------------------------------
  assign rx_bad = (rx_phase_q == err_pkg::PH_DATA) && (^{rx_ad_q, rx_cbe_q, link.dev_par});
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drv_phase_reg <= err_pkg::PH_IDLE;
      drv_ad_reg <= 32'h0000_0000;
      drv_cbe_reg <= 4'h0;
      drv_special_reg <= 1'b0;
      par_reg <= 1'b0;
      serr_oe_reg <= 1'b0;
      perr_oe_reg <= 1'b0;
      rx_phase_q <= err_pkg::PH_IDLE;
      rx_ad_q <= 32'h0000_0000;
      rx_cbe_q <= 4'h0;
      rx_special_q <= 1'b0;
    end else begin
      drv_phase_reg <= drv_phase;
      drv_ad_reg <= drv_ad;
      drv_cbe_reg <= drv_cbe;
      drv_special_reg <= drv_special;
      par_reg <= ^{drv_ad_reg, drv_cbe_reg};
      serr_oe_reg <= report_serr && !serr_oe_reg;
      rx_phase_q <= link.dev_phase;
      rx_ad_q <= link.dev_ad;
      rx_cbe_q <= link.dev_cbe;
      rx_special_q <= link.dev_special;
      perr_oe_reg <= rx_bad && !rx_special_q && parity_check_en;
    end
  end
  assign link.agt_phase = drv_phase_reg;
  assign link.agt_ad = drv_ad_reg;
  assign link.agt_cbe = drv_cbe_reg;
  assign link.agt_special = drv_special_reg;
  assign link.agt_par = par_reg;
  assign link.agt_serr_o = 1'b0;
  assign link.agt_serr_oe = serr_oe_reg;
  assign link.agt_perr_o = 1'b0;
  assign link.agt_perr_oe = perr_oe_reg;
endmodule // core_agent_end
`default_nettype wire

// [design/err_link_if.sv]
/*
  Link between the error reporting unit and the core/PCI agent end.
  Assumes both ends share pclk; the bench instantiates this interface
  and connects both modports. SERR and PERR are open-drain, resolved here.
*/
`timescale 1ns/10ps
`default_nettype none
interface err_link_if;
  logic core_hard_reset_n;
  logic controller_hard_reset_n;
  logic mcp_n;
  logic proc_rd_valid;
  logic [31:0] proc_rd_addr;
  logic nmi;
  logic [31:0] dev_ad;
  logic [3:0] dev_cbe;
  logic dev_par;
  err_pkg::phase_t dev_phase;
  logic dev_special;
  logic [31:0] agt_ad;
  logic [3:0] agt_cbe;
  logic agt_par;
  err_pkg::phase_t agt_phase;
  logic agt_special;
  logic dev_serr_o;
  logic dev_serr_oe;
  logic dev_perr_o;
  logic dev_perr_oe;
  logic agt_serr_o;
  logic agt_serr_oe;
  logic agt_perr_o;
  logic agt_perr_oe;
  logic serr_n;
  logic perr_n;

  // ----------------------------------------
  // Wired-low resolution
  // ----------------------------------------
  assign serr_n = !((dev_serr_oe && !dev_serr_o) || (agt_serr_oe && !agt_serr_o));
  assign perr_n = !((dev_perr_oe && !dev_perr_o) || (agt_perr_oe && !agt_perr_o));

  modport device (
    input core_hard_reset_n, controller_hard_reset_n, proc_rd_valid, proc_rd_addr, nmi,
    input agt_ad, agt_cbe, agt_par, agt_phase, agt_special, serr_n, perr_n,
    output mcp_n, dev_ad, dev_cbe, dev_par, dev_phase, dev_special,
    output dev_serr_o, dev_serr_oe, dev_perr_o, dev_perr_oe
  );
  modport agent (
    output core_hard_reset_n, controller_hard_reset_n, proc_rd_valid, proc_rd_addr, nmi,
    output agt_ad, agt_cbe, agt_par, agt_phase, agt_special,
    output agt_serr_o, agt_serr_oe, agt_perr_o, agt_perr_oe,
    input mcp_n, dev_ad, dev_cbe, dev_par, dev_phase, dev_special, serr_n, perr_n
  );
endinterface
`default_nettype wire

// [design/err_pkg.sv]
/*
  Shared constants for the error reporting unit and its link partner:
  register offsets, field positions, reset values, vector addresses,
  PCI phase codes and the acknowledge state encoding.
  Assumes both ends are compiled after this package.
*/
package err_pkg;
  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_CMD_STATUS = 8'h00;
  localparam logic [7:0] OFS_DETECT1 = 8'h04;
  localparam logic [7:0] OFS_DETECT2 = 8'h08;
  localparam logic [7:0] OFS_PROC_CFG1 = 8'h0c;
  localparam logic [7:0] OFS_ERR_ADDR = 8'h10;
  localparam logic [7:0] OFS_BUS_STATUS = 8'h14;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CMD_PAR_RESP = 6;
  localparam int CMD_SERR_EN = 8;
  localparam int ST_PAR_REPORTED = 8;
  localparam int ST_RX_TABORT = 12;
  localparam int ST_RX_MABORT = 13;
  localparam int ST_SERR_SIGNALLED = 14;
  localparam int ST_PAR_DETECTED = 15;
  localparam int DET1_SRC_PCI = 3;
  localparam int DET1_RX_SERR = 7;
  localparam int DET2_ADDR_INVALID = 7;
  localparam int CFG1_TA_DISABLE = 10;
  localparam int CFG1_MCP_EN = 11;
  // ----------------------------------------
  // Masks and reset values
  // ----------------------------------------
  localparam logic [7:0] DET1_MASK = 8'hf7;
  localparam logic [7:0] DET2_MASK = 8'h39;
  localparam logic [15:0] STATUS_DET_MASK = 16'hb000;
  localparam logic [15:0] STATUS_IMPL_MASK = 16'hf100;
  localparam logic [15:0] CMD_RESET = 16'h0000;
  localparam logic [31:0] PROC_CFG1_RESET = 32'h0000_0000;
  // ----------------------------------------
  // Machine-check vector windows
  // ----------------------------------------
  localparam logic [31:0] MCK_VEC_LOW_BASE = 32'h0000_0200;
  localparam logic [31:0] MCK_VEC_LOW_LAST = 32'h0000_0207;
  localparam logic [31:0] MCK_VEC_HIGH_BASE = 32'hfff0_0200;
  localparam logic [31:0] MCK_VEC_HIGH_LAST = 32'hfff0_0207;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ADDR = 2'b01,
    PH_DATA = 2'b11
  } phase_t;
  typedef enum logic [1:0] {
    AK_IDLE = 2'b00,
    AK_READ = 2'b01,
    AK_WAIT = 2'b11
  } ack_state_t;
endpackage

// [design/error_report_unit.sv]
/*
  Error reporting and machine-check unit: first-error logging, capture
  freeze, machine-check request and acknowledge, PCI SERR/PERR duties,
  APB register access.
  Assumes an APB master on pclk and the core/agent end on the link.
*/
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Both hard resets move together, always
// - Reset aborts, floats, ignores inputs, outputs inactive
// - System reset never touches boundary-scan logic
// - Machine-check request mirrored on external pin
// - One global enable gates every machine check
// - Machine check may rise on any cycle
// - Request held until vector-address read acknowledge
// - SERR for parity, special, aborts, catastrophic
// - Driver of AD drives even PAR later
// - SERR one clock; no retry on parity
// - SERR needs command bits 8,6; sets status14
// - Receiver asserts PERR two clocks after phase
// - PERR not used for special cycles
// - Command bit6 gates PERR; status 15,8 record
// - Enabled external error input raises machine check
// - External error suppressed while detection bit set
// - Detection flags: status 15,13,12; two registers
// - No further reports until all flags clear
// - Simultaneous errors set several flags together
// - Capture registers hold first error only
// - Processor errors clear source and invalid flags
// - Config bit10 clear: assert transfer acknowledge internally
// - Asynchronous error inputs synchronised first
module error_report_unit (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  err_link_if.device link,
  input wire logic [7:0] err1_evt,
  input wire logic [7:0] err2_evt,
  input wire logic evt_src_pci,
  input wire logic evt_addr_invalid,
  input wire logic [31:0] evt_addr,
  input wire logic [15:0] evt_bus_status,
  input wire logic proc_err,
  input wire logic pci_mabort,
  input wire logic pci_mabort_cfg_special,
  input wire logic pci_tabort,
  input wire logic pci_fatal,
  input wire err_pkg::phase_t drv_phase,
  input wire logic [31:0] drv_ad,
  input wire logic [3:0] drv_cbe,
  input wire logic drv_special,
  output logic mcp_pin_n,
  output logic proc_ta
);
  logic rst_n;
  logic nmi_s1;
  logic nmi_s2;
  logic [15:0] cmd_reg;
  logic [15:0] status_reg;
  logic [7:0] det1_reg;
  logic [7:0] det2_reg;
  logic [31:0] cfg1_reg;
  logic [31:0] err_addr_reg;
  logic [15:0] bus_status_reg;
  logic mcp_reg;
  logic ta_reg;
  logic [31:0] prdata_reg;
  logic hit;
  logic [31:0] rd_mux;
  logic wr;
  err_pkg::phase_t drv_phase_reg;
  logic [31:0] drv_ad_reg;
  logic [3:0] drv_cbe_reg;
  logic drv_special_reg;
  logic par_reg;
  err_pkg::phase_t rx_phase_q;
  logic [31:0] rx_ad_q;
  logic [3:0] rx_cbe_q;
  logic rx_special_q;
  logic rx_bad;
  logic addr_perr;
  logic data_perr;
  logic serr_cause;
  logic serr_oe_reg;
  logic perr_oe_reg;
  logic rx_serr;
  logic rx_perr;
  logic [7:0] ev1;
  logic [7:0] ev2;
  logic [15:0] evst;
  logic [15:0] st_set;
  logic any_evt;
  logic det_any;
  logic first;
  logic ack;
  logic mcp_set;

  // ----------------------------------------
  // Reset and synchronisers
  // ----------------------------------------
  // Scan-test state lives elsewhere on its own test reset; nothing here
  // reaches it
  assign rst_n = presetn && link.core_hard_reset_n && link.controller_hard_reset_n;
  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_s1 <= 1'b0;
      nmi_s2 <= 1'b0;
    end else begin
      nmi_s1 <= link.nmi;
      nmi_s2 <= nmi_s1;
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  assign pready = 1'b1;
  assign wr = psel && penable && pwrite;
  always_comb begin
    hit = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      err_pkg::OFS_CMD_STATUS: rd_mux = {status_reg, cmd_reg};
      err_pkg::OFS_DETECT1: rd_mux = {24'h00_0000, det1_reg};
      err_pkg::OFS_DETECT2: rd_mux = {24'h00_0000, det2_reg};
      err_pkg::OFS_PROC_CFG1: rd_mux = cfg1_reg;
      err_pkg::OFS_ERR_ADDR: rd_mux = err_addr_reg;
      err_pkg::OFS_BUS_STATUS: rd_mux = {16'h0000, bus_status_reg};
      default: hit = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !hit;
  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_reg <= rd_mux;
    end
  end
  assign prdata = prdata_reg;
  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_reg <= err_pkg::CMD_RESET;
      cfg1_reg <= err_pkg::PROC_CFG1_RESET;
    end else if (wr && paddr == err_pkg::OFS_CMD_STATUS) begin
      cmd_reg <= pwdata[15:0];
    end else if (wr && paddr == err_pkg::OFS_PROC_CFG1) begin
      cfg1_reg <= pwdata;
    end
  end

  // ----------------------------------------
  // PCI drive and parity check
  // ----------------------------------------
  // Phase at t, parity at t+1, report at t+2
  assign rx_bad = (rx_phase_q != err_pkg::PH_IDLE) && (^{rx_ad_q, rx_cbe_q, link.agt_par});
  assign addr_perr = rx_bad && (rx_phase_q == err_pkg::PH_ADDR);
  assign data_perr = rx_bad && (rx_phase_q == err_pkg::PH_DATA);
  assign rx_serr = !link.serr_n && !serr_oe_reg;
  assign rx_perr = !link.perr_n && !perr_oe_reg;
  assign serr_cause = addr_perr || (data_perr && rx_special_q) || pci_tabort || pci_fatal
    || (pci_mabort && !pci_mabort_cfg_special);
  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      drv_phase_reg <= err_pkg::PH_IDLE;
      drv_ad_reg <= 32'h0000_0000;
      drv_cbe_reg <= 4'h0;
      drv_special_reg <= 1'b0;
      par_reg <= 1'b0;
      rx_phase_q <= err_pkg::PH_IDLE;
      rx_ad_q <= 32'h0000_0000;
      rx_cbe_q <= 4'h0;
      rx_special_q <= 1'b0;
      serr_oe_reg <= 1'b0;
      perr_oe_reg <= 1'b0;
    end else begin
      drv_phase_reg <= drv_phase;
      drv_ad_reg <= drv_ad;
      drv_cbe_reg <= drv_cbe;
      drv_special_reg <= drv_special;
      par_reg <= ^{drv_ad_reg, drv_cbe_reg};
      rx_phase_q <= link.agt_phase;
      rx_ad_q <= link.agt_ad;
      rx_cbe_q <= link.agt_cbe;
      rx_special_q <= link.agt_special;
      serr_oe_reg <= serr_cause && cmd_reg[err_pkg::CMD_SERR_EN]
        && cmd_reg[err_pkg::CMD_PAR_RESP] && !serr_oe_reg;
      perr_oe_reg <= data_perr && !rx_special_q && cmd_reg[err_pkg::CMD_PAR_RESP];
    end
  end
  assign link.dev_phase = drv_phase_reg;
  assign link.dev_ad = drv_ad_reg;
  assign link.dev_cbe = drv_cbe_reg;
  assign link.dev_special = drv_special_reg;
  assign link.dev_par = par_reg;
  assign link.dev_serr_o = 1'b0;
  assign link.dev_serr_oe = serr_oe_reg;
  assign link.dev_perr_o = 1'b0;
  assign link.dev_perr_oe = perr_oe_reg;

  // ----------------------------------------
  // Detection flags
  // ----------------------------------------
  assign ev1 = (err1_evt | {rx_serr, 7'h00}) & err_pkg::DET1_MASK;
  assign ev2 = err2_evt & err_pkg::DET2_MASK;
  always_comb begin
    evst = 16'h0000;
    evst[err_pkg::ST_PAR_DETECTED] = addr_perr || data_perr || rx_serr;
    evst[err_pkg::ST_RX_MABORT] = pci_mabort;
    evst[err_pkg::ST_RX_TABORT] = pci_tabort;
  end
  always_comb begin
    st_set = evst;
    st_set[err_pkg::ST_SERR_SIGNALLED] = serr_oe_reg;
    st_set[err_pkg::ST_PAR_REPORTED] = perr_oe_reg
      || (rx_perr && cmd_reg[err_pkg::CMD_PAR_RESP]);
  end
  assign any_evt = (|ev1) || (|ev2) || (|evst);
  assign det_any = (|(det1_reg & err_pkg::DET1_MASK)) || (|(det2_reg & err_pkg::DET2_MASK))
    || (|(status_reg & err_pkg::STATUS_DET_MASK));
  assign first = any_evt && !det_any;
  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      det1_reg <= 8'h00;
      det2_reg <= 8'h00;
      status_reg <= 16'h0000;
    end else begin
      det1_reg[7:4] <= (det1_reg[7:4] & ~((wr && paddr == err_pkg::OFS_DETECT1)
        ? pwdata[7:4] : 4'h0)) | ev1[7:4];
      det1_reg[2:0] <= (det1_reg[2:0] & ~((wr && paddr == err_pkg::OFS_DETECT1)
        ? pwdata[2:0] : 3'h0)) | ev1[2:0];
      det2_reg[6:0] <= ((det2_reg[6:0] & ~((wr && paddr == err_pkg::OFS_DETECT2)
        ? pwdata[6:0] : 7'h00)) | ev2[6:0]) & err_pkg::DET2_MASK[6:0];
      status_reg <= ((status_reg & ~((wr && paddr == err_pkg::OFS_CMD_STATUS)
        ? pwdata[31:16] : 16'h0000)) | st_set) & err_pkg::STATUS_IMPL_MASK;
      if (first) begin
        det1_reg[err_pkg::DET1_SRC_PCI] <= !proc_err
          && (evt_src_pci || (|evst) || rx_serr);
        det2_reg[err_pkg::DET2_ADDR_INVALID] <= evt_addr_invalid && !proc_err;
      end
    end
  end

  // ----------------------------------------
  // First-error capture
  // ----------------------------------------
  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      err_addr_reg <= 32'h0000_0000;
      bus_status_reg <= 16'h0000;
    end else if (first) begin
      err_addr_reg <= (addr_perr || data_perr) ? rx_ad_q : evt_addr;
      bus_status_reg <= evt_bus_status;
    end
  end

  // ----------------------------------------
  // Machine check and transfer acknowledge
  // ----------------------------------------
  assign ack = link.proc_rd_valid && (((link.proc_rd_addr >= err_pkg::MCK_VEC_LOW_BASE)
    && (link.proc_rd_addr <= err_pkg::MCK_VEC_LOW_LAST))
    || ((link.proc_rd_addr >= err_pkg::MCK_VEC_HIGH_BASE)
    && (link.proc_rd_addr <= err_pkg::MCK_VEC_HIGH_LAST)));
  // A level input still high at the acknowledge keeps it raised
  assign mcp_set = cfg1_reg[err_pkg::CFG1_MCP_EN]
    && (first || (nmi_s2 && !det_any));
  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      mcp_reg <= 1'b0;
      ta_reg <= 1'b0;
    end else begin
      if (mcp_set) begin
        mcp_reg <= 1'b1;
      end else if (ack) begin
        mcp_reg <= 1'b0;
      end
      ta_reg <= proc_err && !cfg1_reg[err_pkg::CFG1_TA_DISABLE];
    end
  end
  assign link.mcp_n = !mcp_reg;
  assign mcp_pin_n = !mcp_reg;
  assign proc_ta = ta_reg;
endmodule // error_report_unit
`default_nettype wire

// [verification/err_link_monitor.sv]
/*
  Checker for the link between the error unit and the core/agent end.
  Assumes the bench wires pclk, presetn and the link signals by name.
*/
`timescale 1ns/10ps
`default_nettype none
module err_link_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic core_hard_reset_n,
  input wire logic controller_hard_reset_n,
  input wire logic mcp_n,
  input wire logic proc_rd_valid,
  input wire logic [31:0] proc_rd_addr,
  input wire logic [31:0] dev_ad,
  input wire logic [3:0] dev_cbe,
  input wire logic dev_par,
  input wire err_pkg::phase_t dev_phase,
  input wire err_pkg::phase_t agt_phase,
  input wire logic agt_special,
  input wire logic dev_serr_oe,
  input wire logic dev_perr_oe
);
  // ----------------------------------------
  // Vector read decode
  // ----------------------------------------
  logic ack;
  assign ack = proc_rd_valid && (proc_rd_addr[31:3] == 29'h0000_0040 ||
    proc_rd_addr[31:3] == 29'h1ffe_0040);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn || !core_hard_reset_n);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  hrst_pair_a: assert property (core_hard_reset_n == controller_hard_reset_n)
    else $error("hard resets differ");
  reset_idle_a: assert property (disable iff (1'b0) !core_hard_reset_n |->
    mcp_n && !dev_serr_oe && !dev_perr_oe) else $error("outputs active in reset");
  mcp_hold_a: assert property (!mcp_n && !ack |=> !mcp_n)
    else $error("machine check dropped early");
  mcp_ack_a: assert property (!mcp_n && ack |=> mcp_n)
    else $error("machine check kept after vector read");
  par_even_a: assert property (dev_phase != err_pkg::PH_IDLE |=>
    (^{$past(dev_ad), $past(dev_cbe), dev_par}) == 1'b0) else $error("odd parity");
  serr_width_a: assert property ($rose(dev_serr_oe) |=> !dev_serr_oe)
    else $error("serr not one clock");
  perr_time_a: assert property ($rose(dev_perr_oe) |->
    $past(agt_phase, 2) == err_pkg::PH_DATA) else $error("perr misplaced");
  perr_special_a: assert property (agt_phase == err_pkg::PH_DATA && agt_special |->
    ##2 !dev_perr_oe) else $error("perr on special cycle");
  cover property (!mcp_n && ack);
  cover property ($rose(dev_serr_oe));
  cover property (agt_phase == err_pkg::PH_DATA && agt_special);
endmodule // err_link_monitor
`default_nettype wire

// [verification/testbench.sv]
/*
  Self-checking bench: both ends joined by the link, APB master.
  Assumes the package, the link interface and both design ends.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
  typedef struct packed {logic [7:0] e1; logic [7:0] e2; logic [7:0] d1; logic [7:0] d2;} row_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic mcp_pin_n, proc_ta, mck_taken, sv, proc_err = 0, src = 0, inv = 0, e;
  logic mab = 0, mabq = 0, tab = 0, spc = 0, srst = 0, nmi_req = 0, srq = 0, cs;
  logic [7:0] paddr = 0, e1 = 0, e2 = 0;
  logic [31:0] pwdata = 0, prdata, rdv, ad = 0, eaddr = 0;
  logic [3:0] cbe = 0;
  logic [4:0] sc [5] = '{5'b11001, 5'b11100, 5'b11110, 5'b10001, 5'b00001};
  err_pkg::phase_t ph = err_pkg::PH_IDLE;
  int bad_count = 0, compares = 0, mcp_cyc = 0, acks = 0, serr_cyc = 0, ta_cyc = 0;
  int i, m0, a0, s0, t0;
  row_t rows [4] = '{{8'hf7, 8'h00, 8'hf7, 8'h00}, {8'h08, 8'hc6, 8'h00, 8'h00},
    {8'h00, 8'h39, 8'h00, 8'h39}, {8'h11, 8'h01, 8'h11, 8'h01}};
  always #20 pclk = ~pclk;
  err_link_if link ();
  error_report_unit u_error_report_unit (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link), .err1_evt(e1), .err2_evt(e2),
    .evt_src_pci(src), .evt_addr_invalid(inv), .evt_addr(eaddr), .evt_bus_status(eaddr[31:16]),
    .proc_err(proc_err), .pci_mabort(mab), .pci_mabort_cfg_special(mabq), .pci_tabort(tab),
    .pci_fatal(1'b0), .drv_phase(ph), .drv_ad(ad), .drv_cbe(cbe), .drv_special(spc),
    .mcp_pin_n(mcp_pin_n), .proc_ta(proc_ta));
  core_agent_end u_core_agent_end (.pclk(pclk), .presetn(presetn), .link(link),
    .sys_reset_req(srst), .nmi_req(nmi_req), .core_machine_check_enable(1'b1),
    .drv_phase(ph), .drv_ad(ad), .drv_cbe(cbe), .drv_special(spc), .report_serr(srq),
    .parity_check_en(1'b1), .mck_taken(mck_taken), .checkstop(cs));
  err_link_monitor u_err_link_monitor (.pclk(pclk), .presetn(presetn),
    .core_hard_reset_n(link.core_hard_reset_n),
    .controller_hard_reset_n(link.controller_hard_reset_n), .mcp_n(link.mcp_n),
    .proc_rd_valid(link.proc_rd_valid), .proc_rd_addr(link.proc_rd_addr),
    .dev_ad(link.dev_ad), .dev_cbe(link.dev_cbe), .dev_par(link.dev_par),
    .dev_phase(link.dev_phase), .agt_phase(link.agt_phase), .agt_special(link.agt_special),
    .dev_serr_oe(link.dev_serr_oe), .dev_perr_oe(link.dev_perr_oe));
  // ----------------------------------------
  // Event counters
  // ----------------------------------------
  always @(posedge pclk) begin
    if (mcp_pin_n === 1'b0) mcp_cyc <= mcp_cyc + 1;
    if (mck_taken === 1'b1) acks <= acks + 1;
    if (link.serr_n === 1'b0) serr_cyc <= serr_cyc + 1;
    if (proc_ta === 1'b1) ta_cyc <= ta_cyc + 1;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task chk(input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x) begin
      bad_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdv = prdata;
    sv = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task ev(input logic [7:0] x1, input logic [7:0] x2, input logic p);
    e1 <= x1; e2 <= x2; proc_err <= p;
    @(posedge pclk);
    e1 <= 8'h00; e2 <= 8'h00; proc_err <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
  task clr;
    apb(1'b1, 8'h04, 32'hff); apb(1'b1, 8'h08, 32'hff);
  endtask
  task finish_test;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Slack of some 25 times the expected run
  initial begin
    #400000;
    bad_count++;
    finish_test;
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    apb(1'b0, 8'h00, 0); chk(rdv, 0);
    apb(1'b0, 8'h0c, 0); chk(rdv, err_pkg::PROC_CFG1_RESET);
    apb(1'b0, 8'h40, 0); chk(sv, 1'b1);
    apb(1'b1, 8'h0c, 32'h800);
    for (i = 0; i < 4; i++) begin
      m0 = mcp_cyc; a0 = acks; e = |{rows[i].d1, rows[i].d2};
      ev(rows[i].e1, rows[i].e2, 1'b0);
      chk(acks - a0, e);
      chk(mcp_cyc > m0, e);
      apb(1'b0, 8'h04, 0); chk(rdv[7:0], rows[i].d1);
      apb(1'b0, 8'h08, 0); chk(rdv[7:0], rows[i].d2);
      clr;
      apb(1'b0, 8'h04, 0); chk(rdv[7:0], 0);
    end
    // First error holds the capture until every flag is gone
    a0 = acks; eaddr <= 32'h1111_0000; ev(8'h03, 8'h00, 1'b0);
    eaddr <= 32'h2222_0000; ev(8'h04, 8'h00, 1'b0);
    apb(1'b1, 8'h04, 32'h1); ev(8'h10, 8'h00, 1'b0);
    apb(1'b0, 8'h10, 0); chk(rdv, 32'h1111_0000);
    apb(1'b0, 8'h14, 0); chk(rdv, 32'h0000_1111);
    apb(1'b0, 8'h04, 0); chk(rdv[7:0], 8'h16);
    chk(acks - a0, 1);
    clr; ev(8'h20, 8'h00, 1'b0);
    apb(1'b0, 8'h10, 0); chk(rdv, 32'h2222_0000);
    chk(acks - a0, 2);
    clr;
    a0 = acks; ev(8'h01, 8'h00, 1'b0); nmi_req <= 1'b1;
    repeat (10) @(posedge pclk);
    nmi_req <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(acks - a0, 1);
    clr; nmi_req <= 1'b1;
    repeat (2) @(posedge pclk);
    nmi_req <= 1'b0;
    repeat (10) @(posedge pclk);
    chk(acks - a0, 2);
    apb(1'b0, 8'h04, 0); chk(rdv[7:0], 0);
    apb(1'b1, 8'h0c, 0); m0 = mcp_cyc; t0 = ta_cyc; src <= 1'b1; inv <= 1'b1;
    ev(8'h01, 8'h01, 1'b1);
    chk(mcp_cyc - m0, 0);
    chk(ta_cyc - t0, 1);
    apb(1'b0, 8'h04, 0); chk(rdv[7:0], 8'h01);
    apb(1'b0, 8'h08, 0); chk(rdv[7:0], 8'h01);
    clr; apb(1'b1, 8'h0c, 32'h400); t0 = ta_cyc;
    ev(8'h01, 8'h00, 1'b1); chk(ta_cyc - t0, 0);
    clr; src <= 1'b0; inv <= 1'b0;
    for (i = 0; i < 5; i++) begin
      apb(1'b1, 8'h00, {16'hffff, 7'h0, sc[i][4], 1'b0, sc[i][3], 6'h0});
      s0 = serr_cyc; mab <= sc[i][2]; mabq <= sc[i][1]; tab <= sc[i][0];
      @(posedge pclk);
      mab <= 1'b0; mabq <= 1'b0; tab <= 1'b0;
      repeat (6) @(posedge pclk);
      e = sc[i][4] & sc[i][3] & (sc[i][0] | (sc[i][2] & !sc[i][1]));
      chk(serr_cyc - s0, e);
      apb(1'b0, 8'h00, 0); chk(rdv[30], e);
      clr;
    end
    s0 = serr_cyc; srq <= 1'b1;
    @(posedge pclk);
    srq <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(serr_cyc - s0, 1);
    apb(1'b0, 8'h04, 0); chk(rdv[7], 1'b1);
    // Special data phases must never draw a parity report
    spc <= 1'b1; cbe <= 4'h1;
    for (i = 0; i < 6; i++) begin
      ph <= i[0] ? err_pkg::PH_DATA : err_pkg::PH_ADDR; ad <= 32'h0101_0101 << i;
      @(posedge pclk);
    end
    ph <= err_pkg::PH_IDLE; spc <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(link.perr_n, 1'b1);
    ev(8'h01, 8'h00, 1'b0); srst <= 1'b1;
    repeat (3) @(posedge pclk);
    srst <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b0, 8'h04, 0); chk(rdv[7:0], 0);
    chk(link.core_hard_reset_n, 1'b1);
    chk(cs, 1'b0);
    finish_test;
  end
endmodule // testbench
`default_nettype wire
